// ---- rtl/pci_mode_config_mux.sv ----
// Contract
// - host or agent role comes only from a reset-time configuration bit
// - internal or external arbiter comes from a second reset-time bit
// - external arbiter: shared pins carry ejector, led and enumeration
// - internal arbiter: shared pins carry request inputs and grant outputs
// - host mode provides three bus clock outputs for agents
// - each clock output toggles only while its own enable is set
// - interrupt output is open drain in both modes
// - bus reset output driven only in host mode
// - target supports hot swap and assumes host's external arbiter
// - external arbiter: first request pin outputs own bus request
// - external arbiter: first grant pin inputs own bus grant
`timescale 1ns/1ps
`default_nettype none
module pci_mode_config_mux (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // reset configuration word bits
    input wire logic hostAgentSelect,
    input wire logic arbiterSelect,
    input wire logic configValid,
    // output clock control
    input wire logic [2:0] busClockOutEnable,
    // parking controls
    input wire logic arbiterParkMode,
    input wire logic busParkBit,
    // core side
    input wire logic intRequest,
    input wire logic busResetRequest,
    input wire logic ownBusRequest,
    input wire logic [2:0] arbGrant,
    input wire logic hotswapLed,
    input wire logic hotswapEnum,
    // request pins: index 0 is two-way
    input wire logic [2:0] reqPinIn,
    output logic req0PinOut,
    output logic req0PinOe,
    // grant pins: index 0 is two-way
    input wire logic gnt0PinIn,
    output logic [2:0] gntPinOut,
    output logic [2:0] gntPinOe,
    // hot swap pin results
    output logic hotswapEjectorIn,
    output logic hotswapLedOut,
    output logic hotswapEnumOut,
    // arbiter side results
    output logic [2:0] arbRequest,
    output logic ownBusGrant,
    // host clocks, reset, interrupt
    output logic [2:0] busClockOut,
    output logic busResetOut,
    output logic busResetOe,
    output logic interruptOut,
    output logic interruptOe,
    // status
    output logic hostMode,
    output logic internalArb,
    output logic busParked
);
    typedef struct packed {
        pcmux_pkg::pcmux_cfg_type cfg;
        logic host;
        logic arb;
        logic [2:0] reqS1;
        logic [2:0] reqS2;
        logic gntS1;
        logic gntS2;
        logic phase;
        logic req0Out;
        logic req0Oe;
        logic [2:0] gntOut;
        logic [2:0] gntOe;
        logic ejector;
        logic ledOut;
        logic enumOut;
        logic [2:0] arbReq;
        logic ownGnt;
        logic rstOut;
        logic rstOe;
        logic intOe;
        logic intOut;
        logic parked;
    } pcmux_state_type;
    pcmux_state_type s_q, s_d;
    logic [2:0] clkRaw;

    // next state: config latch, pin synchronisers, mux
    always_comb begin
        s_d = s_q;
        s_d.phase = ~s_q.phase;
        // configuration caught once after reset, then frozen
        if (s_q.cfg == pcmux_pkg::CFG_WAIT && configValid) begin
            s_d.host = hostAgentSelect;
            s_d.arb = arbiterSelect;
            s_d.cfg = pcmux_pkg::CFG_DONE;
        end
        // pin inputs pass two flops before use
        s_d.reqS1 = reqPinIn;
        s_d.reqS2 = s_q.reqS1;
        s_d.gntS1 = gnt0PinIn;
        s_d.gntS2 = s_q.gntS1;
        if (s_q.arb == pcmux_pkg::ARB_INTERNAL) begin
            s_d.arbReq = s_q.reqS2;
            s_d.req0Out = 1'b0;
            s_d.req0Oe = 1'b0;
            s_d.gntOut = arbGrant;
            s_d.gntOe = 3'h7;
            s_d.ownGnt = 1'b0;
            s_d.ejector = 1'b0;
            s_d.ledOut = 1'b0;
            s_d.enumOut = 1'b0;
        end else begin
            s_d.arbReq = 3'h0;
            s_d.req0Out = ownBusRequest;
            s_d.req0Oe = 1'b1;
            s_d.ownGnt = s_q.gntS2;
            s_d.ejector = s_q.reqS2[1];
            s_d.ledOut = hotswapLed;
            s_d.enumOut = hotswapEnum;
            s_d.gntOut = {hotswapEnum, hotswapLed, 1'b0};
            s_d.gntOe = 3'h6; // grant 0 becomes an input
        end
        // bus reset only driven as host; agent leaves the pin floating
        s_d.rstOut = busResetRequest & s_q.host;
        s_d.rstOe = s_q.host;
        // open drain: only ever pull low
        s_d.intOe = intRequest;
        s_d.intOut = 1'b0; // open drain never drives high, kept in a flop like every output
        // parking honoured only in host mode with internal arbiter
        s_d.parked = s_q.host & s_q.arb & (arbiterParkMode | busParkBit);
        if (!configValid && s_q.cfg == pcmux_pkg::CFG_WAIT) begin
            s_d.intOe = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.host <= pcmux_pkg::HOST_RESET;
            s_q.arb <= pcmux_pkg::ARB_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // one gated clock per output, only in host mode
    for (genvar i = 0; i < pcmux_pkg::NUM_CLK; i++) begin : gClk
        pcmux_clk_gate uGate (
            .clock(clock),
            .reset(reset),
            .enable(busClockOutEnable[i] & s_q.host),
            .phase(s_q.phase),
            .clkOut(clkRaw[i])
        );
    end

    assign busClockOut = clkRaw;
    assign req0PinOut = s_q.req0Out;
    assign req0PinOe = s_q.req0Oe;
    assign gntPinOut = s_q.gntOut;
    assign gntPinOe = s_q.gntOe;
    assign hotswapEjectorIn = s_q.ejector;
    assign hotswapLedOut = s_q.ledOut;
    assign hotswapEnumOut = s_q.enumOut;
    assign arbRequest = s_q.arbReq;
    assign ownBusGrant = s_q.ownGnt;
    assign busResetOut = s_q.rstOut;
    assign busResetOe = s_q.rstOe;
    assign interruptOut = s_q.intOut;
    assign interruptOe = s_q.intOe;
    assign hostMode = s_q.host;
    assign internalArb = s_q.arb;
    assign busParked = s_q.parked;

    // mode steady over two edges; routing is checked one edge later
    sequence extArbSteady;
        !internalArb && $stable(internalArb);
    endsequence
    sequence intArbSteady;
        internalArb && $stable(internalArb);
    endsequence
    sequence agentSteady;
        !hostMode && $stable(hostMode);
    endsequence

    a_cfg_frozen: assert property (@(posedge clock) disable iff (reset)
        s_q.cfg == pcmux_pkg::CFG_DONE |=> $stable(hostMode)) else $error("role changed");
    a_arb_frozen: assert property (@(posedge clock) disable iff (reset)
        s_q.cfg == pcmux_pkg::CFG_DONE |=> $stable(internalArb)) else $error("arb changed");
    a_hs_led: assert property (@(posedge clock) disable iff (reset)
        extArbSteady |=> hotswapLedOut == $past(hotswapLed)) else $error("led not routed");
    // four edges so the synchroniser holds no reset value any more
    a_ejector_in: assert property (@(posedge clock) disable iff (reset)
        !internalArb [*4] |-> hotswapEjectorIn == $past(reqPinIn[1], 3))
        else $error("ejector not routed");
    a_grant_out: assert property (@(posedge clock) disable iff (reset)
        intArbSteady |=> gntPinOut == $past(arbGrant) && gntPinOe == 3'h7)
        else $error("grant not routed");
    a_req0_in: assert property (@(posedge clock) disable iff (reset)
        intArbSteady |=> !req0PinOe) else $error("req0 driven with internal arbiter");
    a_clk_agent: assert property (@(posedge clock) disable iff (reset)
        !hostMode [*4] |-> busClockOut == 3'h0) else $error("clock in agent mode");
    a_int_odrain: assert property (@(posedge clock) disable iff (reset)
        interruptOut == 1'b0) else $error("interrupt driven high");
    a_int_follow: assert property (@(posedge clock) disable iff (reset)
        s_q.cfg == pcmux_pkg::CFG_DONE |=> interruptOe == $past(intRequest))
        else $error("interrupt enable lags request");
    a_rst_agent: assert property (@(posedge clock) disable iff (reset)
        agentSteady |=> !busResetOe) else $error("reset driven as agent");
    a_park_host: assert property (@(posedge clock) disable iff (reset)
        busParked |-> hostMode && internalArb) else $error("parked outside host mode");
    a_req0_out: assert property (@(posedge clock) disable iff (reset)
        extArbSteady |=> req0PinOe && !gntPinOe[0])
        else $error("req0 or gnt0 direction wrong");
    a_gnt0_in: assert property (@(posedge clock) disable iff (reset)
        !internalArb [*4] |-> ownBusGrant == $past(gnt0PinIn, 3))
        else $error("gnt0 not sampled");

    // per output: a disabled clock sits low, an enabled host clock flips every cycle
    for (genvar j = 0; j < pcmux_pkg::NUM_CLK; j++) begin : gClkChk
        a_clk_gated: assert property (@(posedge clock) disable iff (reset)
            !busClockOutEnable[j] [*3] |-> !busClockOut[j]) else $error("clock ran while off");
        a_clk_runs: assert property (@(posedge clock) disable iff (reset)
            (hostMode && busClockOutEnable[j]) [*4] |-> busClockOut[j] != $past(busClockOut[j]))
            else $error("enabled clock stuck");
    end
endmodule
`default_nettype wire

// ---- rtl/pcmux_pkg.sv ----
`default_nettype none
package pcmux_pkg;
    // reset values of the latched configuration
    localparam logic HOST_RESET = 1'b0;
    localparam logic ARB_RESET = 1'b0;
    localparam logic [2:0] CLK_EN_RESET = 3'h0;
    // number of host bus clock outputs
    localparam int NUM_CLK = 3;
    // bus clock: half period in system clock cycles
    localparam int BUS_CLK_HALF = 1;
    // arbiter select encodings
    localparam logic ARB_EXTERNAL = 1'b0;
    localparam logic ARB_INTERNAL = 1'b1;
    // configuration capture states
    typedef enum logic [0:0] {
        CFG_WAIT = 1'b0,
        CFG_DONE = 1'b1
    } pcmux_cfg_type;
endpackage
`default_nettype wire

// ---- rtl/pcmux_clk_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcmux_clk_gate (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // control
    input wire logic enable,
    input wire logic phase,
    // output
    output logic clkOut
);
    typedef struct packed {
        logic run;
        logic out;
    } pcmux_gate_type;
    pcmux_gate_type s_q, s_d;

    // enable sampled only while phase is low, the high half of a running clock, so periods stay whole
    always_comb begin
        s_d = s_q;
        if (!phase) begin
            s_d.run = enable;
        end
        s_d.out = s_d.run & phase;
        if (!s_q.run && !phase) begin
            s_d.out = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clkOut = s_q.out;

    a_gate_low: assert property (@(posedge clock) disable iff (reset)
        !s_q.run |-> !clkOut) else $error("gated clock toggled while off");
endmodule
`default_nettype wire

// ---- testbench/pcmux_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcmux_far_model (
    // device pin drive
    input wire logic req0PinOut,
    input wire logic req0PinOe,
    input wire logic [2:0] gntPinOut,
    input wire logic [2:0] gntPinOe,
    // agents and external arbiter
    input wire logic [2:0] agentReq,
    input wire logic extGrant,
    // resolved pin levels
    output logic [2:0] reqPinIn,
    output logic gnt0PinIn
);
    // pins are pulled up; the low level means asserted, so released never reads stale
    always_comb begin
        reqPinIn = ~agentReq;
        if (req0PinOe) begin
            reqPinIn[0] = req0PinOut;
        end
        gnt0PinIn = gntPinOe[0] ? gntPinOut[0] : ~extGrant;
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
    // design inputs
    logic clock = 1'b0, reset = 1'b1, hostAgentSelect = 1'b0, arbiterSelect = 1'b0;
    logic configValid = 1'b0, arbiterParkMode = 1'b0, busParkBit = 1'b0, intRequest = 1'b0;
    logic busResetRequest = 1'b0, ownBusRequest = 1'b0, hotswapLed = 1'b0, hotswapEnum = 1'b0;
    logic [2:0] busClockOutEnable = 3'h0, arbGrant = 3'h0, agentReq = 3'h0;
    logic extGrant = 1'b0;
    // design outputs and resolved pins
    wire logic [2:0] reqPinIn, gntPinOut, gntPinOe, arbRequest, busClockOut;
    wire logic gnt0PinIn, req0PinOut, req0PinOe, hotswapEjectorIn, hotswapLedOut;
    wire logic hotswapEnumOut, ownBusGrant, busResetOut, busResetOe, interruptOut;
    wire logic interruptOe, hostMode, internalArb, busParked;
    int err_total = 0, checked = 0, n;
    // rises seen in a sixteen-cycle window by an enabled bus clock
    localparam int RISE_COUNT = 16 / (2 * pcmux_pkg::BUS_CLK_HALF);
    logic [2:0] masks [2] = '{3'h5, 3'h2}; // output 1 left off when unused
    pci_mode_config_mux pci_mode_config_mux_inst (.clock, .reset, .hostAgentSelect,
        .arbiterSelect, .configValid, .busClockOutEnable, .arbiterParkMode, .busParkBit,
        .intRequest, .busResetRequest, .ownBusRequest, .arbGrant, .hotswapLed,
        .hotswapEnum, .reqPinIn, .req0PinOut, .req0PinOe, .gnt0PinIn, .gntPinOut,
        .gntPinOe, .hotswapEjectorIn, .hotswapLedOut, .hotswapEnumOut, .arbRequest,
        .ownBusGrant, .busClockOut, .busResetOut, .busResetOe, .interruptOut,
        .interruptOe, .hostMode, .internalArb, .busParked);
    pcmux_far_model pcmux_far_model_inst (.req0PinOut, .req0PinOe, .gntPinOut,
        .gntPinOe, .agentReq, .extGrant, .reqPinIn, .gnt0PinIn);
    always #12.5 clock = ~clock;
    // reset, then present the configuration word once
    task automatic boot(input logic h, input logic a);
        reset = 1'b1;
        configValid = 1'b0;
        hostAgentSelect = h;
        arbiterSelect = a;
        repeat (10) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        configValid = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    // rising edges of one bus clock over sixteen system cycles
    task automatic rises(input int b, output int r);
        logic p;
        p = busClockOut[b];
        r = 0;
        repeat (16) begin
            @(negedge clock);
            if (busClockOut[b] === 1'b1 && p === 1'b0) r++;
            p = busClockOut[b];
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #1000000;
        err_total++;
        print_verdict();
    end
    initial begin
        boot(1'b1, 1'b1);
        `CHK("hostMode", 1'b1, hostMode)
        `CHK("internalArb", 1'b1, internalArb)
        `CHK("gntPinOe", 3'h7, gntPinOe)
        `CHK("req0PinOe", 1'b0, req0PinOe)
        arbGrant = 3'h5;
        agentReq = 3'h6;
        intRequest = 1'b1;
        busResetRequest = 1'b1;
        busParkBit = 1'b1; // park an unused bus
        hostAgentSelect = 1'b0;
        arbiterSelect = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("hostLatched", 1'b1, hostMode)
        `CHK("gntPinOut", 3'h5, gntPinOut)
        `CHK("arbRequest", 3'h1, arbRequest)
        `CHK("hotswapEjectorIn", 1'b0, hotswapEjectorIn)
        `CHK("interruptOe", 1'b1, interruptOe)
        `CHK("interruptOut", 1'b0, interruptOut)
        `CHK("busResetOut", 2'h3, {busResetOe, busResetOut})
        `CHK("busParked", 1'b1, busParked)
        foreach (masks[k]) begin
            busClockOutEnable = masks[k];
            repeat (8) @(negedge clock);
            for (int i = 0; i < 3; i++) begin
                rises(i, n);
                `CHK("busClockRises", (masks[k][i] ? RISE_COUNT : 0), n)
            end
        end
        boot(1'b0, 1'b0);
        ownBusRequest = 1'b1;
        agentReq = 3'h0;
        hotswapLed = 1'b1;
        hotswapEnum = 1'b1;
        intRequest = 1'b0;
        busClockOutEnable = 3'h7;
        repeat (4) @(negedge clock);
        `CHK("req0Pin", 2'h3, {req0PinOe, req0PinOut})
        `CHK("ownBusGrant", 1'b1, ownBusGrant)
        `CHK("gnt0Oe", 1'b0, gntPinOe[0])
        `CHK("hotswapEjectorIn", 1'b1, hotswapEjectorIn)
        `CHK("hotswapOut", 2'h3, {hotswapLedOut, hotswapEnumOut})
        `CHK("arbRequest", 3'h0, arbRequest)
        `CHK("busClockOut", 3'h0, busClockOut)
        `CHK("busResetOe", 1'b0, busResetOe)
        `CHK("busParked", 1'b0, busParked)
        `CHK("interruptOe", 1'b0, interruptOe)
        `CHK("gntPin", 6'h36, {gntPinOe, gntPinOut})
        // drive the far side away from its pull-up levels
        extGrant = 1'b1;
        agentReq = 3'h2;
        ownBusRequest = 1'b0;
        intRequest = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("ownBusGrantLow", 1'b0, ownBusGrant)
        `CHK("ejectorLow", 1'b0, hotswapEjectorIn)
        `CHK("req0PinLow", 2'h2, {req0PinOe, req0PinOut})
        `CHK("interruptAgent", 2'h2, {interruptOe, interruptOut})
        print_verdict();
    end
endmodule
`default_nettype wire
